// ---- rtl/spse_cfg.svh ----
// Purpose: constants for the status pin select and error fill block
// Assumes: register addresses are 7-bit word indices on the control port
// Notes: definitions only
`ifndef SPSE_CFG_SVH
`define SPSE_CFG_SVH

// ==========================================================
// register addresses
`define SPSE_ADDR_W 7
`define SPSE_REG_W 9
`define SPSE_ADDR_SEL12 7'h26
`define SPSE_ADDR_SEL34 7'h27

// ==========================================================
// field positions
`define SPSE_LO_FIELD_LSB 0
`define SPSE_HI_FIELD_LSB 4
`define SPSE_MODE_BIT 8

// ==========================================================
// reset values
`define SPSE_SEL12_RST 9'h010
`define SPSE_SEL34_RST 9'h032

// ==========================================================
// pin count
`define SPSE_PINS 4
`define SPSE_IN_PINS 2

`endif

// ---- rtl/spse_pkg.sv ----
// Purpose: types for the status pin select and error fill block
// Assumes: nothing beyond the cfg header
// Notes: codes follow the 4-bit select field encoding
package spse_pkg;

    // ======================================================
    // pin select codes
    typedef enum logic [3:0] {
        SPSE_SRC_INT_N = 4'h0,
        SPSE_SRC_V = 4'h1,
        SPSE_SRC_U = 4'h2,
        SPSE_SRC_C = 4'h3,
        SPSE_SRC_P = 4'h4,
        SPSE_SRC_SFRM = 4'h5,
        SPSE_SRC_BLK192 = 4'h6,
        SPSE_SRC_UNLOCK = 4'h7,
        SPSE_SRC_CSU = 4'h8,
        SPSE_SRC_INVALID = 4'h9,
        SPSE_SRC_ZERO = 4'hA,
        SPSE_SRC_FLAG_A = 4'hB,
        SPSE_SRC_COPY_N = 4'hC,
        SPSE_SRC_DEEMPH = 4'hD,
        SPSE_SRC_IN_CMOS = 4'hE,
        SPSE_SRC_IN_COMP = 4'hF
    } spse_src_t;

    // ======================================================
    // fill behaviour
    typedef enum logic {
        SPSE_FILL_LAST = 1'b0,
        SPSE_FILL_ZERO = 1'b1
    } spse_fill_t;

endpackage : spse_pkg

// ---- rtl/spse_fill_if.sv ----
// Purpose: carrier between the pin select top and the fill stage
// Assumes: one clock domain
// Notes: top drives controls and samples, fill returns the result
`timescale 1ns/100ps
`default_nettype none

interface spse_fill_if #(parameter int DATA_W = 24);
    logic fill_select;
    logic invalid_handling_disable;
    logic transfer_error_flag;
    logic invalid_flag;
    logic transfer_error_flag_masked;
    logic invalid_masked;
    logic [DATA_W-1:0] in_data;
    logic in_valid;
    logic [DATA_W-1:0] out_data;
    logic out_valid;
    logic out_active;

    modport top (
        output fill_select, invalid_handling_disable,
        output transfer_error_flag, invalid_flag,
        output transfer_error_flag_masked, invalid_masked,
        output in_data, in_valid,
        input out_data, out_valid, out_active
    );

    modport fill (
        input fill_select, invalid_handling_disable,
        input transfer_error_flag, invalid_flag,
        input transfer_error_flag_masked, invalid_masked,
        input in_data, in_valid,
        output out_data, out_valid, out_active
    );
endinterface : spse_fill_if

`default_nettype wire

// ---- rtl/spse_fill.sv ----
// Purpose: replaces receiver samples while a qualifying error flag is set
// Assumes: flags and masks are levels in the receiver clock domain
// Notes: output is one cycle behind the input sample strobe
`timescale 1ns/100ps
`default_nettype none

module spse_fill #(
    parameter int DATA_W = 24
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    spse_fill_if.fill fi
);

    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] data_d;
    logic [DATA_W-1:0] last_q;
    logic [DATA_W-1:0] last_d;
    logic valid_q;
    logic valid_d;
    logic active_q;
    logic active_d;
    logic trans_qual;
    logic inv_qual;
    logic qual;

    // ======================================================
    // qualify and replace
    always_comb begin
        trans_qual = fi.transfer_error_flag_masked & fi.transfer_error_flag;
        inv_qual = fi.invalid_masked & fi.invalid_flag
                   & ~fi.invalid_handling_disable;
        qual = trans_qual | inv_qual;
        data_d = data_q;
        last_d = last_q;
        valid_d = fi.in_valid;
        active_d = qual;
        if (fi.in_valid) begin
            if (qual) begin
                if (fi.fill_select == spse_pkg::SPSE_FILL_ZERO) begin
                    data_d = '0;
                end else begin
                    data_d = last_q;
                end
            end else begin
                data_d = fi.in_data;
                last_d = fi.in_data;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            data_q <= '0;
            last_q <= '0;
            valid_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            data_q <= data_d;
            last_q <= last_d;
            valid_q <= valid_d;
            active_q <= active_d;
        end
    end

    assign fi.out_data = data_q;
    assign fi.out_valid = valid_q;
    assign fi.out_active = active_q;

endmodule : spse_fill

`default_nettype wire

// ---- rtl/spse_top.sv ----
// Purpose: status pin routing for pins 1 to 4 and receiver error fill
// Assumes: all inputs synchronous to ref_clk; masks come from the
//          interrupt mask register outside this block
// Notes: registers are written and read on the control port below
`timescale 1ns/100ps
`default_nettype none
`include "spse_cfg.svh"

module spse_top #(
    parameter int DATA_W = 24
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [`SPSE_ADDR_W-1:0] reg_addr,
    input wire logic [`SPSE_REG_W-1:0] reg_wr_data,
    output logic [`SPSE_REG_W-1:0] reg_rd_data,
    input wire logic interrupt_out_n,
    input wire logic v,
    input wire logic u,
    input wire logic c,
    input wire logic p,
    input wire logic subframe_clock,
    input wire logic block_start_192,
    input wire logic lock_loss_flag,
    input wire logic channel_status_update,
    input wire logic invalid_flag,
    input wire logic zero_detect_flag,
    input wire logic flag_a,
    input wire logic copy_permit_n,
    input wire logic deemphasis_flag,
    input wire logic transfer_error_flag,
    input wire logic transfer_error_flag_masked,
    input wire logic invalid_masked,
    input wire logic [DATA_W-1:0] rx_data,
    input wire logic rx_data_valid,
    output logic [`SPSE_PINS-1:0] pin_out,
    output logic [`SPSE_PINS-1:0] pin_oe,
    input wire logic [`SPSE_IN_PINS-1:0] pin34_in,
    output logic [`SPSE_IN_PINS-1:0] spdif_alt_en,
    output logic [`SPSE_IN_PINS-1:0] spdif_alt_cmp,
    output logic [`SPSE_IN_PINS-1:0] spdif_alt_data,
    output logic [DATA_W-1:0] fill_data,
    output logic fill_data_valid,
    output logic fill_active
);

    // ======================================================
    // helpers
    function automatic logic [3:0] sel_field(
        input logic [`SPSE_REG_W-1:0] r,
        input logic hi
    );
        logic [3:0] f;
        f = hi ? r[`SPSE_HI_FIELD_LSB +: 4] : r[`SPSE_LO_FIELD_LSB +: 4];
        return f;
    endfunction : sel_field

    function automatic logic is_input_code(input logic [3:0] code);
        logic r;
        r = (code == spse_pkg::SPSE_SRC_IN_CMOS)
            || (code == spse_pkg::SPSE_SRC_IN_COMP);
        return r;
    endfunction : is_input_code

    function automatic logic route_source(
        input logic [3:0] code,
        input logic [13:0] srcs
    );
        logic r;
        r = 1'b0;
        if (!is_input_code(code)) begin
            r = srcs[code];
        end
        return r;
    endfunction : route_source

    // ======================================================
    // select registers
    logic [`SPSE_REG_W-1:0] sel12_q;
    logic [`SPSE_REG_W-1:0] sel12_d;
    logic [`SPSE_REG_W-1:0] sel34_q;
    logic [`SPSE_REG_W-1:0] sel34_d;
    logic [`SPSE_REG_W-1:0] rd_data_q;
    logic [`SPSE_REG_W-1:0] rd_data_d;

    always_comb begin
        sel12_d = sel12_q;
        sel34_d = sel34_q;
        if (reg_wr_en) begin
            if (reg_addr == `SPSE_ADDR_SEL12) begin
                sel12_d = reg_wr_data;
            end
            if (reg_addr == `SPSE_ADDR_SEL34) begin
                sel34_d = reg_wr_data;
            end
        end
    end

    // read answers one cycle after the strobe; unmapped reads as zero
    always_comb begin
        rd_data_d = rd_data_q;
        if (reg_rd_en) begin
            case (reg_addr)
                `SPSE_ADDR_SEL12: begin
                    rd_data_d = sel12_q;
                end
                `SPSE_ADDR_SEL34: begin
                    rd_data_d = sel34_q;
                end
                default: begin
                    rd_data_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sel12_q <= `SPSE_SEL12_RST;
            sel34_q <= `SPSE_SEL34_RST;
            rd_data_q <= '0;
        end else begin
            sel12_q <= sel12_d;
            sel34_q <= sel34_d;
            rd_data_q <= rd_data_d;
        end
    end

    assign reg_rd_data = rd_data_q;

    // ======================================================
    // status routing
    logic [13:0] src_vec;
    logic [3:0] code [`SPSE_PINS];
    logic [`SPSE_PINS-1:0] pin_out_q;
    logic [`SPSE_PINS-1:0] pin_out_d;
    logic [`SPSE_PINS-1:0] pin_oe_q;
    logic [`SPSE_PINS-1:0] pin_oe_d;

    assign src_vec = {
        deemphasis_flag,
        copy_permit_n,
        flag_a,
        zero_detect_flag,
        invalid_flag,
        channel_status_update,
        lock_loss_flag,
        block_start_192,
        subframe_clock,
        p,
        c,
        u,
        v,
        interrupt_out_n
    };

    always_comb begin
        code[0] = sel_field(sel12_q, 1'b0);
        code[1] = sel_field(sel12_q, 1'b1);
        code[2] = sel_field(sel34_q, 1'b0);
        code[3] = sel_field(sel34_q, 1'b1);
    end

    // pins 1 and 2 have no input path, so input codes there drive low
    always_comb begin
        for (int i = 0; i < `SPSE_PINS; i++) begin
            pin_out_d[i] = route_source(code[i], src_vec);
            pin_oe_d[i] = 1'b1;
        end
        for (int i = 2; i < `SPSE_PINS; i++) begin
            if (is_input_code(code[i])) begin
                pin_oe_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;

    // ======================================================
    // pins 3 and 4 as receiver inputs
    logic [`SPSE_IN_PINS-1:0] alt_en_q;
    logic [`SPSE_IN_PINS-1:0] alt_en_d;
    logic [`SPSE_IN_PINS-1:0] alt_cmp_q;
    logic [`SPSE_IN_PINS-1:0] alt_cmp_d;
    logic [`SPSE_IN_PINS-1:0] alt_data_q;
    logic [`SPSE_IN_PINS-1:0] alt_data_d;

    // data is gated by the select code, so the first input-mode cycle still carries the level the pin drove out
    always_comb begin
        for (int j = 0; j < `SPSE_IN_PINS; j++) begin
            alt_en_d[j] = 1'b0;
            alt_cmp_d[j] = 1'b0;
            alt_data_d[j] = 1'b0;
            case (code[j+2])
                spse_pkg::SPSE_SRC_IN_CMOS: begin
                    alt_en_d[j] = 1'b1;
                    alt_data_d[j] = pin34_in[j];
                end
                spse_pkg::SPSE_SRC_IN_COMP: begin
                    alt_en_d[j] = 1'b1;
                    alt_cmp_d[j] = 1'b1;
                    alt_data_d[j] = pin34_in[j];
                end
                default: begin
                    alt_en_d[j] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            alt_en_q <= '0;
            alt_cmp_q <= '0;
            alt_data_q <= '0;
        end else begin
            alt_en_q <= alt_en_d;
            alt_cmp_q <= alt_cmp_d;
            alt_data_q <= alt_data_d;
        end
    end

    assign spdif_alt_en = alt_en_q;
    assign spdif_alt_cmp = alt_cmp_q;
    assign spdif_alt_data = alt_data_q;

    // ======================================================
    // error fill stage
    spse_fill_if #(.DATA_W(DATA_W)) fill_bus ();

    // fill kind from pin 1/2 register
    assign fill_bus.fill_select = sel12_q[`SPSE_MODE_BIT];
    // invalid disable from pin 3/4 register
    assign fill_bus.invalid_handling_disable = sel34_q[`SPSE_MODE_BIT];
    assign fill_bus.transfer_error_flag = transfer_error_flag;
    assign fill_bus.invalid_flag = invalid_flag;
    assign fill_bus.transfer_error_flag_masked = transfer_error_flag_masked;
    assign fill_bus.invalid_masked = invalid_masked;
    assign fill_bus.in_data = rx_data;
    assign fill_bus.in_valid = rx_data_valid;

    spse_fill #(
        .DATA_W(DATA_W)
    ) u_fill (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .fi(fill_bus)
    );

    assign fill_data = fill_bus.out_data;
    assign fill_data_valid = fill_bus.out_valid;
    assign fill_active = fill_bus.out_active;

endmodule : spse_top

`default_nettype wire

// ---- verification/spse_top_props.sv ----
// Purpose: port assertions for spse_top
// Assumes: one clock domain, synchronous reset
// Notes: bound to every spse_top instance at the foot of this file
`timescale 1ns/100ps
`default_nettype none
`include "spse_cfg.svh"

module spse_top_props #(
    parameter int DATA_W = 24
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic transfer_error_flag,
    input wire logic transfer_error_flag_masked,
    input wire logic invalid_flag,
    input wire logic invalid_masked,
    input wire logic [DATA_W-1:0] rx_data,
    input wire logic rx_data_valid,
    input wire logic [`SPSE_PINS-1:0] pin_out,
    input wire logic [`SPSE_PINS-1:0] pin_oe,
    input wire logic [`SPSE_IN_PINS-1:0] pin34_in,
    input wire logic [`SPSE_IN_PINS-1:0] spdif_alt_en,
    input wire logic [`SPSE_IN_PINS-1:0] spdif_alt_cmp,
    input wire logic [`SPSE_IN_PINS-1:0] spdif_alt_data,
    input wire logic [DATA_W-1:0] fill_data,
    input wire logic fill_data_valid,
    input wire logic fill_active
);
    // ==========================================================
    // helpers
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    logic te_hit;
    logic inv_hit;
    assign te_hit = transfer_error_flag && transfer_error_flag_masked;
    assign inv_hit = invalid_flag && invalid_masked;

    // ==========================================================
    // fill stage
    chk_fill_strobe: assert property (rx_data_valid |=>
        fill_data_valid) else $error("sample strobe lost");
    chk_fill_hold: assert property (!rx_data_valid |=>
        !fill_data_valid && $stable(fill_data))
        else $error("output moved without sample");
    chk_clean_pass: assert property (
        rx_data_valid && !te_hit && !inv_hit |=>
        fill_data == $past(rx_data)) else $error("clean sample altered");
    chk_err_active: assert property (te_hit |=> fill_active)
        else $error("masked transfer error not acted on");
    chk_quiet_idle: assert property (!te_hit && !inv_hit |=>
        !fill_active) else $error("fill without qualifying flag");

    // ==========================================================
    // pins
    chk_low_drive: assert property (!sys_rst |=>
        pin_oe[1:0] == 2'h3) else $error("pin 1 or 2 released");
    chk_input_oe: assert property (!sys_rst |=>
        pin_oe[3:2] == ~spdif_alt_en) else $error("input pin still driven");
    chk_input_low: assert property (
        (pin_out[3:2] & spdif_alt_en) == 2'h0)
        else $error("input pin still shows a level");
    chk_cmp_mode: assert property (
        (spdif_alt_cmp & ~spdif_alt_en) == 2'h0)
        else $error("comparator chosen outside input mode");
    chk_alt_data: assert property (!sys_rst |=>
        spdif_alt_data == (spdif_alt_en & $past(pin34_in)))
        else $error("receiver input data wrong");

    cover property (fill_active && fill_data_valid);
    cover property (spdif_alt_cmp[1]);
    cover property (fill_data_valid && !fill_active);
endmodule : spse_top_props

bind spse_top spse_top_props #(.DATA_W(DATA_W)) u_props (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .transfer_error_flag(transfer_error_flag),
    .transfer_error_flag_masked(transfer_error_flag_masked), .invalid_flag(invalid_flag),
    .invalid_masked(invalid_masked), .rx_data(rx_data),
    .rx_data_valid(rx_data_valid), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin34_in(pin34_in), .spdif_alt_en(spdif_alt_en),
    .spdif_alt_cmp(spdif_alt_cmp), .spdif_alt_data(spdif_alt_data),
    .fill_data(fill_data), .fill_data_valid(fill_data_valid),
    .fill_active(fill_active)
);

`default_nettype wire

// ---- verification/spse_pin_peer.sv ----
// Purpose: far side of pins 3 and 4
// Assumes: one clock domain
// Notes: sends a 2-bit count when a pin is an input; pin 3 toggles every cycle, pin 4 every second cycle
`timescale 1ns/100ps
`default_nettype none

module spse_pin_peer (
    input wire logic ref_clk,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    output logic [1:0] pin34_in
);
    // ==========================================================
    // stream source
    logic [1:0] pat_q = 2'h0;
    always @(posedge ref_clk) begin
        pat_q <= pat_q + 2'h1;
    end
    assign pin34_in = (pin_oe[3:2] & pin_out[3:2]) | (~pin_oe[3:2] & pat_q);
endmodule : spse_pin_peer

`default_nettype wire

// ---- verification/tb.sv ----
// Purpose: self-checking bench for spse_top
// Assumes: 10 MHz ref_clk, synchronous reset
// Notes: register tasks, sample task, pin peer model
`timescale 1ns/100ps
`default_nettype none

module tb;
    // ==========================================================
    // signals
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [8:0] reg_wr_data = 9'h000;
    logic [8:0] reg_rd_data;
    logic [13:0] src = 14'h000A;
    logic terr = 1'b0;
    logic terr_m = 1'b0;
    logic inv_m = 1'b0;
    logic [23:0] rx_data = 24'h000000;
    logic rx_data_valid = 1'b0;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [1:0] pin34_in;
    logic [1:0] alt_en;
    logic [1:0] alt_cmp;
    logic [1:0] alt_data;
    logic [23:0] fill_data;
    logic fill_data_valid;
    logic fill_active;
    logic [1:0] cap;
    int errors = 0;
    int checked = 0;

    always #50 ref_clk = ~ref_clk;

    spse_top #(.DATA_W(24)) uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .interrupt_out_n(src[0]), .v(src[1]), .u(src[2]), .c(src[3]),
        .p(src[4]), .subframe_clock(src[5]), .block_start_192(src[6]),
        .lock_loss_flag(src[7]), .channel_status_update(src[8]),
        .invalid_flag(src[9]), .zero_detect_flag(src[10]),
        .flag_a(src[11]), .copy_permit_n(src[12]),
        .deemphasis_flag(src[13]), .transfer_error_flag(terr),
        .transfer_error_flag_masked(terr_m), .invalid_masked(inv_m),
        .rx_data(rx_data), .rx_data_valid(rx_data_valid),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin34_in(pin34_in),
        .spdif_alt_en(alt_en), .spdif_alt_cmp(alt_cmp),
        .spdif_alt_data(alt_data), .fill_data(fill_data),
        .fill_data_valid(fill_data_valid), .fill_active(fill_active)
    );
    spse_pin_peer peer (.ref_clk(ref_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin34_in(pin34_in));

    // ==========================================================
    // tasks
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [8:0] exp);
        @(posedge ref_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        #1 check(reg_rd_data, exp);
    endtask : rd

    // flags are {transfer error, its mask, invalid, its mask}
    task automatic smp(input logic [3:0] f, input logic [23:0] d,
        input logic [23:0] exp, input logic act);
        @(posedge ref_clk);
        {terr, terr_m, src[9], inv_m} <= f;
        rx_data <= d;
        rx_data_valid <= 1'b1;
        @(posedge ref_clk);
        rx_data_valid <= 1'b0;
        #1 check(fill_data, exp);
        check(fill_data_valid, 1'b1);
        check(fill_active, act);
    endtask : smp

    task automatic close_out();
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    // ==========================================================
    // watchdog, about twenty times the expected run
    initial begin
        #400000;
        errors++;
        close_out();
    end

    // ==========================================================
    // tests
    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check(pin_out, 4'hA);
        check(pin_oe, 4'hF);
        wr(7'h25, 9'h1FF);
        rd(7'h26, 9'h010);
        rd(7'h27, 9'h032);
        rd(7'h25, 9'h000);
        for (int k = 0; k < 14; k++) begin
            wr(7'h26, {1'b0, k[3:0], k[3:0]});
            wr(7'h27, {1'b0, k[3:0], k[3:0]});
            @(posedge ref_clk);
            src <= 14'h1 << k;
            repeat (2) @(posedge ref_clk);
            #1 check(pin_out, 4'hF);
            @(posedge ref_clk);
            src <= ~(14'h1 << k);
            repeat (2) @(posedge ref_clk);
            #1 check(pin_out, 4'h0);
        end
        @(posedge ref_clk);
        src <= 14'h3FFF;
        wr(7'h26, 9'h0EF);
        wr(7'h27, 9'h0FE);
        @(posedge ref_clk);
        #1 cap = pin34_in;
        @(posedge ref_clk);
        #1 check(pin_out, 4'h0);
        check(pin_oe, 4'h3);
        check(alt_en, 2'h3);
        check(alt_cmp, 2'h2);
        check(alt_data, cap);
        rd(7'h27, 9'h0FE);
        wr(7'h27, 9'h0EF);
        repeat (2) @(posedge ref_clk);
        #1 check(alt_cmp, 2'h1);
        check(alt_en, 2'h3);
        wr(7'h27, 9'h032);
        smp(4'h8, 24'h123456, 24'h123456, 1'b0);
        smp(4'hC, 24'h654321, 24'h123456, 1'b1);
        wr(7'h26, 9'h110);
        smp(4'hC, 24'h654321, 24'h000000, 1'b1);
        smp(4'h3, 24'hABCDEF, 24'h000000, 1'b1);
        wr(7'h27, 9'h132);
        smp(4'h3, 24'hABCDEF, 24'hABCDEF, 1'b0);
        wr(7'h26, 9'h010);
        smp(4'h2, 24'h777777, 24'h777777, 1'b0);
        wr(7'h27, 9'h032);
        smp(4'h3, 24'h111111, 24'h777777, 1'b1);
        rd(7'h26, 9'h010);
        // reset in mid-run brings back the codes and clears the last sample
        wr(7'h26, 9'h1FF);
        wr(7'h27, 9'h1FF);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check(pin_out, 4'hF);
        check(pin_oe, 4'hF);
        check(alt_en, 2'h0);
        rd(7'h26, 9'h010);
        rd(7'h27, 9'h032);
        smp(4'h3, 24'h222222, 24'h000000, 1'b1);
        close_out();
    end
endmodule : tb

`default_nettype wire
